// File: common/uec_pkg.sv
// constants for the unit error checker: error codes, transfer limits
// assumes one clock domain; no software-visible registers
// ==========================================================
// What this block does
// (RULE1) damaged second-task program at power-up reports code 0004
// (RULE2) damaged-parameter and damaged-program checks run once after power-up only; only the program check is built here, no parameter check exists
// (RULE3) slowdown halt reports 0010; reset clears, reraised while request persists
// (RULE4) new unit/machine parameters downloaded report 0011; reset clears it
// (RULE5) damaged position data on receive or block read reports 0012; resettable
// (RULE6) bad read address or count (range, BCD, 4-byte units) reports 0014
// (RULE7) bad write address, count, granularity or size mismatch reports 0015
// (RULE8) non-BCD or out-of-range write value reports 0016
// (RULE9) failed nonvolatile save reports 0017; cleared by a later good save
// (RULE10) host corrects request and reissues transfer after syntax or data error
// (RULE11) damaged-program error ignores reset; clears when task programs all deleted
// (RULE12) active codes held in a status word; reset clears only resettable ones
package uec_pkg;
  localparam logic [15:0] CODE_TASK2_DAMAGE = 16'h0004;
  localparam logic [15:0] CODE_SLOWDOWN = 16'h0010;
  localparam logic [15:0] CODE_SETUP = 16'h0011;
  localparam logic [15:0] CODE_POS_DATA = 16'h0012;
  localparam logic [15:0] CODE_READ_FAULT = 16'h0014;
  localparam logic [15:0] CODE_WRITE_FAULT = 16'h0015;
  localparam logic [15:0] CODE_VALUE_FAULT = 16'h0016;
  localparam logic [15:0] CODE_SAVE_FAIL = 16'h0017;
  localparam logic [15:0] CODE_NONE = 16'h0000;
  // status bit positions, highest priority first when reporting
  localparam int B_TASK2 = 0;
  localparam int B_SLOW = 1;
  localparam int B_SETUP = 2;
  localparam int B_POS = 3;
  localparam int B_RD = 4;
  localparam int B_WR = 5;
  localparam int B_VAL = 6;
  localparam int B_SAVE = 7;
  localparam int NUM_ERR = 8;
  localparam logic [7:0] RESETTABLE = 8'hfe;
  localparam logic [3:0] UNIT_BYTES = 4'h4;
endpackage

// File: rtl/bcd_check.sv
// combinational BCD validity and value check of one 4-digit word
// assumes data is packed as four BCD nibbles
`timescale 1ns/1ps
module bcd_check #(
  parameter int DIGITS = 4
) (
  input wire logic [4*DIGITS-1:0] value_i,
  input wire logic [4*DIGITS-1:0] low_i,
  input wire logic [4*DIGITS-1:0] high_i,
  output logic ok_o
);
  logic [DIGITS-1:0] digit_ok;
  genvar g;
  generate
    for (g = 0; g < DIGITS; g++) begin : g_dig
      assign digit_ok[g] = (value_i[4*g+3 -: 4] <= 4'h9);
    end
  endgenerate
  // whole-word binary compare is fine since BCD keeps ordering
  assign ok_o = (&digit_ok) && (value_i >= low_i) && (value_i <= high_i);
endmodule

// File: rtl/unit_error_checker.sv
// error detection and reporting of a motion control unit
// assumes host requests are single-cycle pulses synchronous to MCLK_I
`timescale 1ns/1ps
module unit_error_checker #(
  parameter logic [15:0] ADDR_MAX = 16'h9999,
  parameter logic [15:0] COUNT_MAX = 16'h0128,
  parameter logic [15:0] VALUE_MAX = 16'h9999
) (
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic POWERUP_CHECK_I,
  input wire logic TASK2_DAMAGED_I,
  input wire logic TASK2_ALL_DELETED_I,
  input wire logic SLOWDOWN_HALT_I,
  input wire logic NEW_PARAMS_LOADED_I,
  input wire logic POS_DATA_DAMAGED_I,
  input wire logic BLOCK_READ_REQUEST_I,
  input wire logic BLOCK_WRITE_REQUEST_I,
  input wire logic [15:0] XFER_ADDR_I,
  input wire logic [15:0] XFER_COUNT_I,
  input wire logic [15:0] TARGET_SIZE_I,
  input wire logic WRITE_VALUE_VALID_I,
  input wire logic [15:0] WRITE_VALUE_I,
  input wire logic SAVE_DONE_I,
  input wire logic SAVE_OK_I,
  input wire logic ERROR_RESET_I,
  output logic [7:0] ERR_STATUS_O,
  output logic [15:0] ERR_CODE_O
);
  logic [7:0] err;
  logic [7:0] set_ev;
  logic [7:0] clr_ev;
  logic checked;
  logic addr_ok;
  logic cnt_ok;
  logic val_ok;
  logic cnt_unit;
  logic [15:0] next_code;

  // ==========================================================
  // request checks
  bcd_check #(.DIGITS(4)) u_addr (
    .value_i(XFER_ADDR_I),
    .low_i(16'h0000),
    .high_i(ADDR_MAX),
    .ok_o(addr_ok)
  );
  bcd_check #(.DIGITS(4)) u_cnt (
    .value_i(XFER_COUNT_I),
    .low_i(16'h0001),
    .high_i(COUNT_MAX),
    .ok_o(cnt_ok)
  );
  bcd_check #(.DIGITS(4)) u_val (
    .value_i(WRITE_VALUE_I),
    .low_i(16'h0000),
    .high_i(VALUE_MAX),
    .ok_o(val_ok)
  );
  // BCD count: multiple of 4 decided by tens parity and units digit
  always_comb begin
    if (XFER_COUNT_I[4]) begin
      cnt_unit = (XFER_COUNT_I[3:0] == 4'h2) || (XFER_COUNT_I[3:0] == 4'h6);
    end else begin
      cnt_unit = (XFER_COUNT_I[3:0] == 4'h0) || (XFER_COUNT_I[3:0] == 4'h4)
        || (XFER_COUNT_I[3:0] == 4'h8);
    end
  end

  // ==========================================================
  // events
  always_comb begin
    set_ev = 8'h00;
    clr_ev = 8'h00;
    set_ev[uec_pkg::B_TASK2] = POWERUP_CHECK_I && !checked && TASK2_DAMAGED_I; // RULE1 RULE2
    set_ev[uec_pkg::B_SLOW] = SLOWDOWN_HALT_I; // RULE3
    set_ev[uec_pkg::B_SETUP] = NEW_PARAMS_LOADED_I; // RULE4
    set_ev[uec_pkg::B_POS] = POS_DATA_DAMAGED_I; // RULE5
    set_ev[uec_pkg::B_RD] = BLOCK_READ_REQUEST_I && !(addr_ok && cnt_ok && cnt_unit); // RULE6
    set_ev[uec_pkg::B_WR] = BLOCK_WRITE_REQUEST_I
      && !(addr_ok && cnt_ok && cnt_unit && XFER_COUNT_I == TARGET_SIZE_I); // RULE7
    set_ev[uec_pkg::B_VAL] = WRITE_VALUE_VALID_I && !val_ok; // RULE8
    set_ev[uec_pkg::B_SAVE] = SAVE_DONE_I && !SAVE_OK_I; // RULE9
    clr_ev[uec_pkg::B_SAVE] = SAVE_DONE_I && SAVE_OK_I; // RULE9
    clr_ev[uec_pkg::B_TASK2] = TASK2_ALL_DELETED_I; // RULE11
    // only resettable codes drop on error reset
    if (ERROR_RESET_I) begin
      clr_ev = clr_ev | uec_pkg::RESETTABLE; // RULE12 RULE11
    end
  end

  // ==========================================================
  // power-up check runs once
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      checked <= 1'b0;
    end else if (POWERUP_CHECK_I) begin
      checked <= 1'b1; // RULE2
    end
  end

  // sticky flags; set wins over clear so a simultaneous cause is kept
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      err <= 8'h00;
    end else begin
      err <= (err & ~clr_ev) | set_ev; // RULE12 RULE3
    end
  end

  always_comb begin
    next_code = uec_pkg::CODE_NONE;
    if (err[uec_pkg::B_SAVE]) next_code = uec_pkg::CODE_SAVE_FAIL;
    if (err[uec_pkg::B_VAL]) next_code = uec_pkg::CODE_VALUE_FAULT;
    if (err[uec_pkg::B_WR]) next_code = uec_pkg::CODE_WRITE_FAULT;
    if (err[uec_pkg::B_RD]) next_code = uec_pkg::CODE_READ_FAULT;
    if (err[uec_pkg::B_POS]) next_code = uec_pkg::CODE_POS_DATA;
    if (err[uec_pkg::B_SETUP]) next_code = uec_pkg::CODE_SETUP;
    if (err[uec_pkg::B_SLOW]) next_code = uec_pkg::CODE_SLOWDOWN;
    if (err[uec_pkg::B_TASK2]) next_code = uec_pkg::CODE_TASK2_DAMAGE;
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ERR_STATUS_O <= 8'h00;
      ERR_CODE_O <= 16'h0000;
    end else begin
      ERR_STATUS_O <= err; // RULE12
      ERR_CODE_O <= next_code;
    end
  end

  // ==========================================================
  // checks
  property p_task2_sticky;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      err[uec_pkg::B_TASK2] && !TASK2_ALL_DELETED_I |=> err[uec_pkg::B_TASK2];
  endproperty
  a_task2_sticky: assert property (p_task2_sticky) else $error("task2 error lost"); // RULE11

  property p_task2_once;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      checked && !err[uec_pkg::B_TASK2] |=> !err[uec_pkg::B_TASK2];
  endproperty
  a_task2_once: assert property (p_task2_once) else $error("late program check"); // RULE2

  property p_slow_reraise;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      SLOWDOWN_HALT_I |=> err[uec_pkg::B_SLOW] ##1 ERR_STATUS_O[uec_pkg::B_SLOW];
  endproperty
  a_slow_reraise: assert property (p_slow_reraise) else $error("halt not held"); // RULE3

  property p_setup_clr;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      ERROR_RESET_I && !NEW_PARAMS_LOADED_I |=> !err[uec_pkg::B_SETUP];
  endproperty
  a_setup_clr: assert property (p_setup_clr) else $error("setup not cleared"); // RULE4

  property p_pos_set;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      POS_DATA_DAMAGED_I |=> err[uec_pkg::B_POS];
  endproperty
  a_pos_set: assert property (p_pos_set) else $error("data error missed"); // RULE5

  property p_rd_odd;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      BLOCK_READ_REQUEST_I && XFER_COUNT_I == 16'h0006 |=> err[uec_pkg::B_RD];
  endproperty
  a_rd_odd: assert property (p_rd_odd) else $error("read granularity missed"); // RULE6

  property p_wr_size;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      BLOCK_WRITE_REQUEST_I && XFER_COUNT_I != TARGET_SIZE_I |=> err[uec_pkg::B_WR];
  endproperty
  a_wr_size: assert property (p_wr_size) else $error("size mismatch missed"); // RULE7

  property p_val_bcd;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      WRITE_VALUE_VALID_I && WRITE_VALUE_I[3:0] > 4'h9 |=> err[uec_pkg::B_VAL];
  endproperty
  a_val_bcd: assert property (p_val_bcd) else $error("bad value missed"); // RULE8

  property p_save_clr;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      SAVE_DONE_I && SAVE_OK_I |=> !err[uec_pkg::B_SAVE] ##1 !ERR_STATUS_O[uec_pkg::B_SAVE];
  endproperty
  a_save_clr: assert property (p_save_clr) else $error("save error kept"); // RULE9

  property p_task2_set;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      POWERUP_CHECK_I && !checked && TASK2_DAMAGED_I |=> err[uec_pkg::B_TASK2]
        ##1 ERR_STATUS_O[uec_pkg::B_TASK2];
  endproperty
  a_task2_set: assert property (p_task2_set) else $error("program damage missed"); // RULE1

  property p_slow_clr;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      ERROR_RESET_I && !SLOWDOWN_HALT_I |=> !err[uec_pkg::B_SLOW];
  endproperty
  a_slow_clr: assert property (p_slow_clr) else $error("halt not cleared"); // RULE3

  property p_pos_clr;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      ERROR_RESET_I && !POS_DATA_DAMAGED_I |=> !err[uec_pkg::B_POS];
  endproperty
  a_pos_clr: assert property (p_pos_clr) else $error("data error not cleared"); // RULE5

  property p_rd_addr;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      BLOCK_READ_REQUEST_I && XFER_ADDR_I[3:0] > 4'h9 |=> err[uec_pkg::B_RD];
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("read address missed"); // RULE6

  property p_wr_addr;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      BLOCK_WRITE_REQUEST_I && XFER_ADDR_I[15:12] > 4'h9 |=> err[uec_pkg::B_WR];
  endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("write address missed"); // RULE7

  property p_save_set;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      SAVE_DONE_I && !SAVE_OK_I |=> err[uec_pkg::B_SAVE] ##1 ERR_STATUS_O[uec_pkg::B_SAVE];
  endproperty
  a_save_set: assert property (p_save_set) else $error("save failure missed"); // RULE9

  property p_code_idle;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      ERR_STATUS_O == 8'h00 |-> ERR_CODE_O == uec_pkg::CODE_NONE;
  endproperty
  a_code_idle: assert property (p_code_idle) else $error("code without status"); // RULE12
endmodule

// File: bench/host_model.sv
// host controller model: issues block read and write requests
// assumes tasks are called from the bench, one request at a time
`timescale 1ns/1ps
module host_model (
  input wire logic clk_i,
  output logic rd_o,
  output logic wr_o,
  output logic vld_o,
  output logic [15:0] addr_o,
  output logic [15:0] count_o,
  output logic [15:0] size_o,
  output logic [15:0] value_o
);
  initial begin
    {rd_o, wr_o, vld_o} = 3'h0;
    {addr_o, count_o, size_o, value_o} = 64'h0;
  end
  // ==========================================================
  // one-cycle request; fields scrambled after, stale values must not count
  task automatic xfer(input logic w, input logic [15:0] a, c, s, v);
    @(posedge clk_i);
    {rd_o, wr_o, vld_o} <= {!w, w, w};
    {addr_o, count_o, size_o, value_o} <= {a, c, s, v};
    @(posedge clk_i);
    {rd_o, wr_o, vld_o} <= 3'h0;
    {addr_o, count_o, size_o, value_o} <= ~{a, c, s, v};
  endtask
endmodule

// File: bench/tb_unit_error_checker.sv
// self-checking bench of the unit error checker
// assumes default parameters: count limit 0128, address and value limit 9999
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module tb_unit_error_checker;
  logic MCLK_I = 1'b0, RSTN_I = 1'b0, dmg = 1'b0, halt = 1'b0, sok = 1'b1;
  logic rd, wr, vld;
  logic [5:0] pl = 6'h0;
  logic [15:0] a, c, s, v, CODE;
  logic [7:0] ST, e;
  int err_total = 0, check_count = 0, cyc = 0, seed = 67102;
  initial forever #4 MCLK_I = ~MCLK_I;
  host_model host_model_inst (.clk_i(MCLK_I), .rd_o(rd), .wr_o(wr), .vld_o(vld),
    .addr_o(a), .count_o(c), .size_o(s), .value_o(v));
  unit_error_checker unit_error_checker_inst (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I),
    .POWERUP_CHECK_I(pl[0]), .TASK2_DAMAGED_I(dmg), .TASK2_ALL_DELETED_I(pl[1]),
    .SLOWDOWN_HALT_I(halt), .NEW_PARAMS_LOADED_I(pl[2]), .POS_DATA_DAMAGED_I(pl[3]),
    .BLOCK_READ_REQUEST_I(rd), .BLOCK_WRITE_REQUEST_I(wr), .XFER_ADDR_I(a),
    .XFER_COUNT_I(c), .TARGET_SIZE_I(s), .WRITE_VALUE_VALID_I(vld), .WRITE_VALUE_I(v),
    .SAVE_DONE_I(pl[4]), .SAVE_OK_I(sok), .ERROR_RESET_I(pl[5]), .ERR_STATUS_O(ST),
    .ERR_CODE_O(CODE));
  // ==========================================================
  // expectation helpers
  function automatic bit bcd(input logic [15:0] x);
    return x[3:0] < 10 && x[7:4] < 10 && x[11:8] < 10 && x[15:12] < 10;
  endfunction
  function automatic bit cnt_ok(input logic [15:0] x);
    int d;
    d = x[15:12] * 1000 + x[11:8] * 100 + x[7:4] * 10 + x[3:0];
    return bcd(x) && d > 0 && d <= 128 && d % 4 == 0;
  endfunction
  function automatic logic [15:0] prio(input logic [7:0] x);
    logic [15:0] t [8] = '{16'h0004, 16'h0010, 16'h0011, 16'h0012, 16'h0014,
      16'h0015, 16'h0016, 16'h0017};
    prio = 16'h0000;
    for (int i = 7; i >= 0; i--) if (x[i]) prio = t[i];
  endfunction
  // ==========================================================
  // drivers and checks; outputs answer one edge after the sampling edge
  task automatic pulse(input int i);
    @(posedge MCLK_I) pl <= 6'h1 << i;
    @(posedge MCLK_I) pl <= 6'h0;
  endtask
  task automatic chk(input logic [7:0] x);
    repeat (2) @(posedge MCLK_I);
    #1;
    `CHK(ST, x)
    `CHK(CODE, prio(x))
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge MCLK_I) if (++cyc == 20000) begin
    err_total++;
    complete_run();
  end
  initial begin
    logic w;
    logic [15:0] ra, rc, rs, rv;
    logic [15:0] corner [6] = '{16'h0006, 16'h0008, 16'h0000, 16'h0132, 16'h0128, 16'h00a8};
    repeat (12) @(posedge MCLK_I);
    RSTN_I <= 1'b1;
    chk(8'h00);
    dmg <= 1'b1;
    pulse(0); chk(8'h01);
    pulse(5); chk(8'h01);
    pulse(1); chk(8'h00);
    pulse(0); chk(8'h00);
    $display("test power-up done");
    @(posedge MCLK_I) halt <= 1'b1;
    pulse(5); chk(8'h02);
    @(posedge MCLK_I) halt <= 1'b0;
    pulse(5); chk(8'h00);
    pulse(2); chk(8'h04);
    pulse(3); chk(8'h0c);
    pulse(5); chk(8'h00);
    @(posedge MCLK_I) sok <= 1'b0;
    pulse(4); chk(8'h80);
    @(posedge MCLK_I) sok <= 1'b1;
    pulse(4); chk(8'h00);
    $display("test events done");
    for (int i = 0; i < 40; i++) begin
      w = (i >= 6) && i[0];
      ra = 16'($random(seed));
      ra = i[1] ? ra : ra & 16'h7777;
      rc = (i < 6) ? corner[i] : (16'($random(seed)) & 16'h0137);
      rs = (i % 3 == 0) ? rc + 16'h4 : rc;
      rv = i[2] ? 16'($random(seed)) : 16'h1234;
      e = 8'h00;
      e[4] = !w && !(bcd(ra) && cnt_ok(rc));
      e[5] = w && !(bcd(ra) && cnt_ok(rc) && rs == rc);
      e[6] = w && !bcd(rv);
      host_model_inst.xfer(w, ra, rc, rs, rv);
      chk(e);
      if (e != 8'h00) begin
        pulse(5);
        // corrected request is taken cleanly after the fault
        host_model_inst.xfer(w, 16'h0100, 16'h0004, 16'h0004, 16'h0099);
        chk(8'h00);
      end
    end
    $display("test transfers done");
    complete_run();
  end
endmodule
